// *** core/spi_status_data_crc_regs.sv ***
// Chosen here: strobed register access.
`timescale 1ns/100ps
`include "spi_serial_regs.svh"
module spi_status_data_crc_regs
  import spi_serial_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        sclkPin,
  input  wire logic        csNPin,
  input  wire logic        mosiPin,
  input  wire logic        wsPin,
  output logic             misoPin,
  output logic             misoOeN,
  output logic             irq
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  pin_t              syn1_ff;
  pin_t              syn2_ff;
  logic              sclkD_ff;
  logic              csND_ff;
  link_state_t       state_ff;
  logic [3:0]        bitCnt_ff;
  logic [15:0]       rxSh_ff;
  logic [15:0]       txSh_ff;
  logic              miso_ff;
  logic              misoOeN_ff;
  logic              enable_ff;
  logic              crc_enable_ff;
  logic              crcNext_ff;
  logic              audio_ff;
  logic              rxNeIe_ff;
  logic [3:0]        widthSel_ff;
  logic [15:0]       poly_ff;
  logic [15:0]       crc_ff;
  logic [15:0]       rxMem [DEPTH];
  logic [15:0]       txMem [DEPTH];
  logic [PW-1:0]     rxWp_ff;
  logic [PW-1:0]     rxRp_ff;
  logic [PW:0]       rxCnt_ff;
  logic [PW-1:0]     txWp_ff;
  logic [PW-1:0]     txRp_ff;
  logic [PW:0]       txCnt_ff;
  logic              udr_ff;
  logic              crcErr_ff;
  logic              modeF_ff;
  logic              ovr_ff;
  logic              frameF_ff;
  logic              busy_ff;
  logic              side_ff;
  logic [5:0]        ists_ff;
  logic [5:0]        imask_ff;
  logic              irq_ff;
  logic [15:0]       rdata_ff;
  logic [15:0]       rdVal;
  logic [5:0]        events;

  function automatic logic [1:0] fillLevel(input logic [PW:0] cnt);
    if (cnt == '0)
      return 2'h0;
    else if (cnt <= FULL / 4)
      return 2'h1;
    else if (cnt <= FULL / 2)
      return 2'h2;
    else
      return 2'h3;
  endfunction : fillLevel

  function automatic logic [15:0] widthMask(input logic [3:0] last);
    return 16'hFFFF >> (4'hF - last);
  endfunction : widthMask

  function automatic logic [15:0] crcStep(input logic [15:0] crc,
                                          input logic        din,
                                          input logic [15:0] poly,
                                          input logic        wide);
    logic        fb;
    logic [15:0] nxt;
    fb  = (wide ? crc[15] : crc[7]) ^ din;
    nxt = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    return wide ? nxt : {8'h00, nxt[7:0]};
  endfunction : crcStep

  wire logic        rise      = syn2_ff.sclk & ~sclkD_ff;
  wire logic        fall      = ~syn2_ff.sclk & sclkD_ff;
  wire logic        csActive  = ~syn2_ff.csN;
  wire logic        csFall    = csND_ff & ~syn2_ff.csN;
  wire logic [3:0]  lastIdx   = audio_ff ? 4'hF : widthSel_ff;
  wire logic        wideCrc   = lastIdx > 4'h7;
  wire logic        inShift   = state_ff == ST_SHIFT;
  wire logic        frameStart = (state_ff == ST_IDLE) & csActive
                                 & enable_ff;
  wire logic        frameDone = inShift & csActive & rise
                                & (bitCnt_ff == lastIdx);
  wire logic        frameAbort = inShift & ~csActive
                                 & (bitCnt_ff != 4'h0);
  wire logic [15:0] rxWord    = {rxSh_ff[14:0], syn2_ff.mosi}
                                & widthMask(lastIdx);
  wire logic        rxFull    = rxCnt_ff == FULL;
  wire logic        txFull    = txCnt_ff == FULL;
  wire logic        txEmpty   = txCnt_ff == '0;
  wire logic        rxNotEmpty = rxCnt_ff != '0;
  wire logic        wrData    = wr & (addr == `OFS_DATA);
  wire logic        rdData    = rd & (addr == `OFS_DATA);
  wire logic        wrStat    = wr & (addr == `OFS_STATUS);
  wire logic        rdStat    = rd & (addr == `OFS_STATUS);
  wire logic        wrCtrl    = wr & (addr == `OFS_CTRL);
  wire logic        rxPush    = frameDone & ~rxFull;
  wire logic        rxPop     = rdData & rxNotEmpty;
  wire logic        txPush    = wrData & ~txFull;
  wire logic        wordLoad  = frameStart | frameDone;
  wire logic        txPop     = wordLoad & ~txEmpty;
  wire logic [15:0] crcNxt    = crcStep(crc_ff, syn2_ff.mosi, poly_ff,
                                        wideCrc);
  wire logic        ovrEv     = frameDone & rxFull;
  wire logic        udrEv     = wordLoad & txEmpty & audio_ff;
  wire logic        crcEv     = frameDone & crcNext_ff & ~audio_ff
                                & (crcNxt != 16'h0000);
  wire logic        modeEv    = csFall & ~enable_ff;
  wire logic        crcClr    = wrCtrl & wdata[`CT_CRC_ENABLE] & ~crc_enable_ff;

  assign events = {modeEv, frameAbort, udrEv, ovrEv, crcEv, frameDone};

  // pins cross into core_clk through two flops
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      syn1_ff  <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0, ws: 1'b0};
      syn2_ff  <= '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0, ws: 1'b0};
      sclkD_ff <= 1'b0;
      csND_ff  <= 1'b1;
    end else begin
      syn1_ff  <= '{sclk: sclkPin, csN: csNPin, mosi: mosiPin, ws: wsPin};
      syn2_ff  <= syn1_ff;
      sclkD_ff <= syn2_ff.sclk;
      csND_ff  <= syn2_ff.csN;
    end
  end

  // control register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      enable_ff   <= 1'b0;
      crc_enable_ff    <= 1'b0;
      audio_ff    <= 1'b0;
      rxNeIe_ff   <= 1'b0;
      widthSel_ff <= `RST_WIDTH;
    end else if (wrCtrl) begin
      enable_ff <= wdata[`CT_EN];
      crc_enable_ff  <= wdata[`CT_CRC_ENABLE];
      audio_ff  <= wdata[`CT_AUDIO];
      rxNeIe_ff <= wdata[`CT_RXNEIE];
      if (wdata[11:8] < `WIDTH_MIN)
        widthSel_ff <= `RST_WIDTH;
      else
        widthSel_ff <= wdata[11:8];
    end
  end

  // crc-next marks the following frame as the received CRC
  always_ff @(posedge core_clk) begin
    if (!nrst)
      crcNext_ff <= 1'b0;
    else if (wrCtrl)
      crcNext_ff <= wdata[`CT_CRCNXT];
    else if (frameDone)
      crcNext_ff <= 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      poly_ff <= `RST_POLY;
    else if (wr && addr == `OFS_POLY)
      poly_ff <= wdata;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      crc_ff <= 16'h0000;
    else if (crcClr)
      crc_ff <= 16'h0000;
    else if (inShift && csActive && rise && crc_enable_ff && !audio_ff)
      crc_ff <= crcNxt;
  end

  // link sequencing
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_ff  <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      rxSh_ff   <= 16'h0000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          bitCnt_ff <= 4'h0;
          if (frameStart)
            state_ff <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (!csActive) begin
            state_ff  <= ST_IDLE;
            bitCnt_ff <= 4'h0;
          end else if (rise) begin
            rxSh_ff   <= {rxSh_ff[14:0], syn2_ff.mosi};
            bitCnt_ff <= frameDone ? 4'h0 : bitCnt_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // transmit word cut to the frame width
  always_ff @(posedge core_clk) begin
    if (!nrst)
      txSh_ff <= 16'h0000;
    else if (wordLoad)
      txSh_ff <= txPop ? txMem[txRp_ff] & widthMask(lastIdx) : 16'h0000;
    else if (inShift && fall)
      txSh_ff <= {txSh_ff[14:0], 1'b0};
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      miso_ff    <= 1'b0;
      misoOeN_ff <= 1'b1;
    end else begin
      miso_ff    <= txSh_ff[lastIdx];
      misoOeN_ff <= ~(csActive & enable_ff);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rxWp_ff  <= '0;
      rxRp_ff  <= '0;
      rxCnt_ff <= '0;
    end else begin
      if (rxPush)
        rxWp_ff <= PW'((rxWp_ff + 1'b1) % DEPTH);
      if (rxPop)
        rxRp_ff <= PW'((rxRp_ff + 1'b1) % DEPTH);
      rxCnt_ff <= rxCnt_ff + (PW+1)'(rxPush) - (PW+1)'(rxPop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rxPush)
      rxMem[rxWp_ff] <= rxWord;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      txWp_ff  <= '0;
      txRp_ff  <= '0;
      txCnt_ff <= '0;
    end else begin
      if (txPush)
        txWp_ff <= PW'((txWp_ff + 1'b1) % DEPTH);
      if (txPop)
        txRp_ff <= PW'((txRp_ff + 1'b1) % DEPTH);
      txCnt_ff <= txCnt_ff + (PW+1)'(txPush) - (PW+1)'(txPop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (txPush)
      txMem[txWp_ff] <= wdata;
  end

  // status flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      udr_ff    <= 1'b0;
      crcErr_ff <= 1'b0;
      modeF_ff  <= 1'b0;
      ovr_ff    <= 1'b0;
    end else begin
      udr_ff    <= udrEv | (udr_ff & ~(wrStat & ~wdata[`ST_UDR]));
      crcErr_ff <= crcEv | (crcErr_ff & ~(wrStat & ~wdata[`ST_CRCE]));
      modeF_ff  <= modeEv | (modeF_ff & ~(wrStat & ~wdata[`ST_MODEF]));
      ovr_ff    <= ovrEv | (ovr_ff & ~(wrStat & ~wdata[`ST_OVR]));
    end
  end

  // read of status clears frame fault
  always_ff @(posedge core_clk) begin
    if (!nrst)
      frameF_ff <= 1'b0;
    else
      frameF_ff <= frameAbort | (frameF_ff & ~rdStat);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      side_ff <= 1'b0;
    end else begin
      busy_ff <= inShift & csActive;
      // channel of the word being started
      if (wordLoad && audio_ff)
        side_ff <= syn2_ff.ws;
    end
  end

  // interrupt status, write one to clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ists_ff  <= 6'h00;
      imask_ff <= 6'h00;
    end else begin
      if (wr && addr == `OFS_IMASK)
        imask_ff <= wdata[5:0];
      if (wr && addr == `OFS_ISTAT)
        ists_ff <= events | (ists_ff & ~wdata[5:0]);
      else
        ists_ff <= events | ists_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      irq_ff <= 1'b0;
    else
      irq_ff <= (|(ists_ff & imask_ff)) | (rxNeIe_ff & rxNotEmpty);
  end

  always_comb begin
    rdVal = 16'h0000;
    case (addr)
      `OFS_STATUS: begin
        rdVal[0]     = rxNotEmpty;
        rdVal[1]     = txEmpty;
        rdVal[2]     = audio_ff & side_ff;
        rdVal[3]     = udr_ff;
        rdVal[4]     = crcErr_ff;
        rdVal[5]     = modeF_ff;
        rdVal[6]     = ovr_ff;
        rdVal[7]     = busy_ff;
        rdVal[8]     = frameF_ff;
        rdVal[10:9]  = audio_ff ? 2'h0 : fillLevel(rxCnt_ff);
        rdVal[12:11] = audio_ff ? 2'h0 : fillLevel(txCnt_ff);
      end
      `OFS_DATA:  rdVal = rxNotEmpty ? rxMem[rxRp_ff] : 16'h0000;
      `OFS_POLY:  rdVal = poly_ff;
      `OFS_RX_CRC_ACCUM: rdVal = crc_ff;
      `OFS_CTRL:  rdVal = {4'h0, widthSel_ff, 3'h0, rxNeIe_ff, audio_ff,
                           crcNext_ff, crc_enable_ff, enable_ff};
      `OFS_ISTAT: rdVal = {10'h000, ists_ff};
      `OFS_IMASK: rdVal = {10'h000, imask_ff};
      default:    rdVal = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      rdata_ff <= 16'h0000;
    else
      rdata_ff <= rd ? rdVal : 16'h0000;
  end

  assign rdata   = rdata_ff;
  assign misoPin = miso_ff;
  assign misoOeN = misoOeN_ff;
  assign irq     = irq_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_rxne_read: assert property (
    rd && addr == `OFS_STATUS |=> rdata[0] == $past(rxCnt_ff != '0))
    else $error("rx not empty flag wrong");
  a_txe_write: assert property (
    wrData && txEmpty && !wordLoad |=> rdata[1] == 1'b0 && !txEmpty)
    else $error("tx empty not cleared by write");
  a_crc_clear: assert property (
    crcClr |=> crc_ff == 16'h0000)
    else $error("rx crc not cleared on enable");
  a_width_fix: assert property (
    wrCtrl && wdata[11:8] < 4'h3 |=> widthSel_ff == 4'h7)
    else $error("reserved width not forced");
  a_frmf_rdclr: assert property (
    rdStat && !frameAbort |=> !frameF_ff)
    else $error("frame fault not cleared by read");
  a_ovr_set: assert property (
    frameDone && rxFull |=> ovr_ff && rxCnt_ff == FULL - (PW+1)'($past(rxPop)))
    else $error("overrun not flagged");
  a_crce_w0: assert property (
    wrStat && !wdata[4] && !crcEv |=> !crcErr_ff ##1 crcErr_ff == $past(crcEv))
    else $error("crc error clear wrong");
  a_txlvl_full: assert property (
    rd && addr == `OFS_STATUS && !audio_ff && txCnt_ff > FULL / 2
    |=> rdata[12:11] == 2'h3)
    else $error("tx level above half not full");
  a_busy_link: assert property (
    inShift && csActive |=> busy_ff ##1 (busy_ff || !$past(csActive)))
    else $error("busy flag wrong");
  a_irq_rxne: assert property (
    rxNeIe_ff && rxNotEmpty |=> irq)
    else $error("rx not empty interrupt missing");
  a_rdata_gap: assert property (
    !rd |=> rdata == 16'h0000)
    else $error("read data outside its cycle");

  c_frame_done: cover property (frameDone && rxPush);
  c_overrun:    cover property (ovrEv);
  c_crc_match:  cover property (frameDone && crcNext_ff && !crcEv);
  c_abort:      cover property (frameAbort);

endmodule : spi_status_data_crc_regs

// *** shared/spi_serial_pkg.sv ***
package spi_serial_pkg;
  typedef struct packed {
    logic sclk;
    logic csN;
    logic mosi;
    logic ws;
  } pin_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } link_state_t;
endpackage : spi_serial_pkg

// *** shared/spi_serial_regs.svh ***
`ifndef SPI_SERIAL_REGS_SVH
`define SPI_SERIAL_REGS_SVH
`define OFS_STATUS  8'h08
`define OFS_DATA    8'h0C
`define OFS_POLY    8'h10
`define OFS_RX_CRC_ACCUM   8'h14
`define OFS_CTRL    8'h24
`define OFS_ISTAT   8'h28
`define OFS_IMASK   8'h2C
`define ST_UDR      3
`define ST_CRCE     4
`define ST_MODEF    5
`define ST_OVR      6
`define CT_EN       0
`define CT_CRC_ENABLE    1
`define CT_CRCNXT   2
`define CT_AUDIO    3
`define CT_RXNEIE   4
`define RST_POLY    16'h0007
`define RST_WIDTH   4'h7
`define WIDTH_MIN   4'h3
`define EV_RXDONE   0
`define EV_CRCE     1
`define EV_OVR      2
`define EV_UDR      3
`define EV_FRAMEF   4
`define EV_MODEF    5
`endif

// *** sim/spi_host_model.sv ***
`timescale 1ns/100ps
module spi_host_model (
  output logic      sclk,
  output logic      csN,
  output logic      mosi,
  output logic      ws,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    csN  = 1'b1;
    mosi = 1'b0;
    ws   = 1'b0;
  end
  // clock idles low, mode 0: drive before rise, sample at rise
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx  = '0;
    // keep pin changes off the core_clk edges so miso settles before rise
    #3;
    csN = 1'b0;
    #160;
    for (int i = n - 1; i >= 0; i--) begin
      mosi = tx[i];
      #80 sclk = 1'b1;
      rx = {rx[14:0], miso};
      #80 sclk = 1'b0;
    end
    #80 csN = 1'b1;
    // released line shows no stale level
    mosi = ~mosi;
    #160;
  endtask : xfer
  task automatic sel(input logic lvl);
    csN = lvl;
    #160;
  endtask : sel
  task automatic side(input logic lvl);
    ws = lvl;
  endtask : side
endmodule : spi_host_model

// *** sim/spi_status_data_crc_regs_tb.sv ***
`timescale 1ns/100ps
`include "spi_serial_regs.svh"
module spi_status_data_crc_regs_tb;
  import spi_serial_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        sclk;
  logic        csN;
  logic        mosi;
  logic        ws;
  logic        miso;
  logic        misoOeN;
  logic        irq;
  logic [15:0] v;
  logic [15:0] rx;
  int          nFail    = 0;
  int          nChecks  = 0;
  int          cyc      = 0;
  // pulled-up wire while the device does not drive it
  wire         misoWire = misoOeN ? 1'b1 : miso;

  spi_status_data_crc_regs #(.DEPTH(4)) spi_status_data_crc_regs_inst (
    .core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sclkPin(sclk), .csNPin(csN),
    .mosiPin(mosi), .wsPin(ws), .misoPin(miso), .misoOeN(misoOeN),
    .irq(irq));
  spi_host_model spi_host_model_inst (
    .sclk(sclk), .csN(csN), .mosi(mosi), .ws(ws), .miso(misoWire));

  always #10 core_clk = ~core_clk;

  task automatic printVerdict();
    if (nFail == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : printVerdict

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      nFail++;
      printVerdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr    <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask : rreg
  task automatic rchk(input logic [7:0] a, input logic [15:0] m,
                      input logic [15:0] e);
    rreg(a);
    chk(v & m, e);
  endtask : rchk
  task automatic irqChk(input logic e);
    repeat (2) @(posedge core_clk);
    #1 chk({15'h0000, irq}, {15'h0000, e});
  endtask : irqChk
  function automatic logic [15:0] crcOf(input logic [15:0] d, input int w);
    logic [15:0] c = '0;
    logic [15:0] m = 16'((1 << w) - 1);
    for (int i = w - 1; i >= 0; i--) begin
      c = ({c[14:0], 1'b0} ^ ((c[w-1] ^ d[i]) ? 16'h0007 : 16'h0000)) & m;
    end
    return c;
  endfunction : crcOf

  task automatic tRegs();
    rchk(`OFS_POLY, 16'hFFFF, 16'h0007);
    wreg(`OFS_POLY, 16'h8005);
    rchk(`OFS_POLY, 16'hFFFF, 16'h8005);
    wreg(`OFS_POLY, 16'h0007);
    rchk(`OFS_STATUS, 16'h1FFF, 16'h0002);
    rchk(`OFS_DATA, 16'hFFFF, 16'h0000);
    rchk(8'h40, 16'hFFFF, 16'h0000);
  endtask : tRegs

  task automatic tFifo();
    logic [1:0] lv [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3};
    for (int k = 0; k < 5; k++) begin
      wreg(`OFS_DATA, 16'hA5C0 + 16'(k));
      rchk(`OFS_STATUS, 16'h1802, {3'h0, lv[k], 11'h000});
    end
    wreg(`OFS_CTRL, 16'h0711);
    for (int k = 0; k < 5; k++) begin
      spi_host_model_inst.xfer(16'h0030 + 16'(k), 8, rx);
      if (k < 4) begin
        // frame end preloads the next word, lost when select rises
        chk(rx, k == 0 ? 16'h00C0 :
                (k == 1 ? 16'h00C2 : 16'h0000));
        rchk(`OFS_STATUS, 16'h0601, {5'h00, lv[k], 9'h001});
        irqChk(1'b1);
      end
    end
    wreg(`OFS_STATUS, 16'hFFFF);
    rchk(`OFS_STATUS, 16'h0040, 16'h0040);
    wreg(`OFS_STATUS, 16'h0000);
    rchk(`OFS_STATUS, 16'h0040, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      rchk(`OFS_DATA, 16'hFFFF,
           k < 4 ? 16'h0030 + 16'(k) : 16'h0000);
    end
    rchk(`OFS_STATUS, 16'h0601, 16'h0000);
    irqChk(1'b0);
    rchk(`OFS_ISTAT, 16'h0005, 16'h0005);
    wreg(`OFS_IMASK, 16'h0004);
    irqChk(1'b1);
    wreg(`OFS_ISTAT, 16'h0004);
    irqChk(1'b0);
    rchk(`OFS_ISTAT, 16'h0005, 16'h0001);
  endtask : tFifo

  task automatic tFaults();
    spi_host_model_inst.sel(1'b0);
    rchk(`OFS_STATUS, 16'h0080, 16'h0080);
    spi_host_model_inst.sel(1'b1);
    // only a frame cut after some bits raises the frame fault
    spi_host_model_inst.xfer(16'h0000, 4, rx);
    rchk(`OFS_STATUS, 16'h0181, 16'h0100);
    rchk(`OFS_STATUS, 16'h0100, 16'h0000);
    wreg(`OFS_CTRL, 16'h0700);
    spi_host_model_inst.sel(1'b0);
    spi_host_model_inst.sel(1'b1);
    rchk(`OFS_STATUS, 16'h0020, 16'h0020);
    wreg(`OFS_STATUS, 16'h0000);
    rchk(`OFS_STATUS, 16'h0020, 16'h0000);
  endtask : tFaults

  task automatic tWidth();
    wreg(`OFS_CTRL, 16'h0101);
    rchk(`OFS_CTRL, 16'h0F00, 16'h0700);
    wreg(`OFS_CTRL, 16'h0301);
    rchk(`OFS_CTRL, 16'h0F00, 16'h0300);
    wreg(`OFS_DATA, 16'h00F9);
    spi_host_model_inst.xfer(16'h0006, 4, rx);
    chk(rx, 16'h0009);
    rchk(`OFS_DATA, 16'hFFFF, 16'h0006);
    wreg(`OFS_CTRL, 16'h0F01);
    wreg(`OFS_DATA, 16'hBEEF);
    spi_host_model_inst.xfer(16'h1234, 16, rx);
    chk(rx, 16'hBEEF);
    rchk(`OFS_DATA, 16'hFFFF, 16'h1234);
  endtask : tWidth

  task automatic tCrc();
    logic [15:0] c;
    c = crcOf(16'h005A, 8);
    wreg(`OFS_CTRL, 16'h0703);
    spi_host_model_inst.xfer(16'h005A, 8, rx);
    rchk(`OFS_RX_CRC_ACCUM, 16'hFFFF, c);
    wreg(`OFS_CTRL, 16'h0707);
    spi_host_model_inst.xfer(c ^ 16'h0001, 8, rx);
    rchk(`OFS_STATUS, 16'h0010, 16'h0010);
    wreg(`OFS_STATUS, 16'h0000);
    rchk(`OFS_STATUS, 16'h0010, 16'h0000);
    wreg(`OFS_CTRL, 16'h0701);
    wreg(`OFS_CTRL, 16'h0703);
    rchk(`OFS_RX_CRC_ACCUM, 16'hFFFF, 16'h0000);
    rreg(`OFS_DATA);
    rreg(`OFS_DATA);
  endtask : tCrc

  task automatic tAudio();
    wreg(`OFS_CTRL, 16'h0709);
    spi_host_model_inst.side(1'b1);
    spi_host_model_inst.xfer(16'h0000, 16, rx);
    rchk(`OFS_STATUS, 16'h000C, 16'h000C);
    wreg(`OFS_DATA, 16'h1357);
    spi_host_model_inst.side(1'b0);
    spi_host_model_inst.xfer(16'h0000, 16, rx);
    chk(rx, 16'h1357);
    rchk(`OFS_STATUS, 16'h000C, 16'h0008);
    wreg(`OFS_STATUS, 16'h0000);
    rchk(`OFS_STATUS, 16'h0008, 16'h0000);
  endtask : tAudio

  initial begin
    nrst  <= 1'b0;
    addr  <= 8'h00;
    wdata <= 16'h0000;
    wr    <= 1'b0;
    rd    <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    tRegs();
    tFifo();
    tFaults();
    tWidth();
    tCrc();
    tAudio();
    printVerdict();
  end
endmodule : spi_status_data_crc_regs_tb
